// >>> pkg/brsc_defs.svh
// offsets, field positions, reset values and routing codes of the route control bank
`ifndef BRSC_DEFS_SVH
`define BRSC_DEFS_SVH

// ************************************************************
// register offsets inside the logic window
// ************************************************************
`define BRSC_ADDR_W 4
`define BRSC_OFS_PIN_CFG 4'h8
`define BRSC_OFS_LINE_DATA 4'h9
`define BRSC_OFS_LINE_CLOCK 4'ha
`define BRSC_OFS_OVERHEAD 4'hb
`define BRSC_OFS_SERIAL_DATA 4'hc
`define BRSC_OFS_FRAME_CLOCK 4'hd

// ************************************************************
// reset values
// ************************************************************
`define BRSC_RST_PIN_CFG 8'h08
`define BRSC_RST_LINE_DATA 8'h08
`define BRSC_RST_LINE_CLOCK 8'h00
`define BRSC_RST_OVERHEAD 8'h00
`define BRSC_RST_SERIAL_DATA 8'h00
`define BRSC_RST_FRAME_CLOCK 8'h00
`define BRSC_MASK_LOW_NIB 8'h0f
`define BRSC_READ_NONE 8'h00

// ************************************************************
// transceiver pin configuration fields
// ************************************************************
`define BRSC_BIT_CLK_POL 7
`define BRSC_BIT_CLK_PHASE 6
`define BRSC_BIT_BIT_SWAP 5
`define BRSC_BIT_BUS_MODE 4
`define BRSC_BIT_FLOAT_TEST 3
`define BRSC_BIT_WIDTH 2
`define BRSC_BIT_STROBE 1
`define BRSC_BIT_ADDR_MUX 0

// ************************************************************
// routing codes and per-field valid code masks
// ************************************************************
`define BRSC_CODE_FLOAT 4'h0
`define BRSC_CODE_LOOP 4'h1
`define BRSC_CODE_LOW 4'h6
`define BRSC_CODE_HIGH 4'h7
`define BRSC_CODE_LAST 4'h7
`define BRSC_VALID_LINE 8'hfe
`define BRSC_VALID_TWO_SRC 8'hc6
`define BRSC_VALID_ONE_SRC 8'hc2

`endif

// >>> pkg/brsc_pkg.sv
// types shared by the route control bank
package brsc_pkg;

    typedef logic [7:0] brsc_reg_t;
    typedef logic [3:0] brsc_code_t;
    typedef logic [3:0] brsc_addr_t;

    typedef enum logic [1:0]
    {
        BRSC_BUS_IDLE  = 2'b00,
        BRSC_BUS_WRITE = 2'b01,
        BRSC_BUS_READ  = 2'b10
    } brsc_bus_state_t;

endpackage

// >>> pkg/brsc_reg_if.sv
// register access and register contents between bus front end and register bank
`timescale 1ns/1ps
interface brsc_reg_if;
    import brsc_pkg::*;

    logic wr_stb;
    brsc_addr_t addr;
    brsc_reg_t wdata;
    brsc_reg_t rdata;
    brsc_reg_t pin_cfg;
    brsc_reg_t line_data;
    brsc_reg_t line_clock;
    brsc_reg_t overhead;
    brsc_reg_t serial_data;
    brsc_reg_t frame_clock;

    modport bank
    (
        input wr_stb, addr, wdata,
        output rdata, pin_cfg, line_data, line_clock, overhead, serial_data, frame_clock
    );

    modport user
    (
        output wr_stb, addr, wdata,
        input rdata, pin_cfg, line_data, line_clock, overhead, serial_data, frame_clock
    );
endinterface

// >>> src/brsc_route_sel.sv
// one routing selector: code picks a source, a constant level, or high impedance
`timescale 1ns/1ps
`include "brsc_defs.svh"
module brsc_route_sel
    import brsc_pkg::*;
#(
    parameter logic [7:0] VALID = 8'hfe
)
(
    // clock and control
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // selection
    input wire brsc_code_t code_in,
    input wire logic [4:0] src_in,
    // routed line
    output logic val_out,
    output logic oe_out
);
    logic [7:0] choice;

    // code 6 low, code 7 high, codes 1..5 from the sources
    assign choice = {1'b1, 1'b0, src_in, 1'b0};

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            val_out <= 1'b0;
            oe_out <= 1'b0;
        end
        else if (ce_in)
        begin
            // codes above 7 and unused codes float the line
            if (code_in <= `BRSC_CODE_LAST && VALID[code_in[2:0]])
            begin
                oe_out <= 1'b1;
                val_out <= choice[code_in[2:0]];
            end
            else
            begin
                oe_out <= 1'b0;
                val_out <= 1'b0;
            end
        end
    end
endmodule

// >>> src/brsc_reg_bank.sv
// control register storage and read-back
`timescale 1ns/1ps
`include "brsc_defs.svh"
module brsc_reg_bank
    import brsc_pkg::*;
(
    // clock and control
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // register access
    brsc_reg_if.bank bus
);
    logic wr_ok;

    assign wr_ok = ce_in && bus.wr_stb;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            bus.pin_cfg <= `BRSC_RST_PIN_CFG;
            bus.line_data <= `BRSC_RST_LINE_DATA;
            bus.line_clock <= `BRSC_RST_LINE_CLOCK;
            bus.overhead <= `BRSC_RST_OVERHEAD;
            bus.serial_data <= `BRSC_RST_SERIAL_DATA;
            bus.frame_clock <= `BRSC_RST_FRAME_CLOCK;
        end
        else if (wr_ok)
        begin
            case (bus.addr)
                `BRSC_OFS_PIN_CFG: bus.pin_cfg <= bus.wdata;
                `BRSC_OFS_LINE_DATA: bus.line_data <= bus.wdata;
                // upper nibble not stored, so it reads back zero
                `BRSC_OFS_LINE_CLOCK: bus.line_clock <= bus.wdata & `BRSC_MASK_LOW_NIB;
                `BRSC_OFS_OVERHEAD: bus.overhead <= bus.wdata;
                `BRSC_OFS_SERIAL_DATA: bus.serial_data <= bus.wdata & `BRSC_MASK_LOW_NIB;
                `BRSC_OFS_FRAME_CLOCK: bus.frame_clock <= bus.wdata;
                default:
                begin
                end
            endcase
        end
    end

    always_comb
    begin
        case (bus.addr)
            `BRSC_OFS_PIN_CFG: bus.rdata = bus.pin_cfg;
            `BRSC_OFS_LINE_DATA: bus.rdata = bus.line_data;
            `BRSC_OFS_LINE_CLOCK: bus.rdata = bus.line_clock;
            `BRSC_OFS_OVERHEAD: bus.rdata = bus.overhead;
            `BRSC_OFS_SERIAL_DATA: bus.rdata = bus.serial_data;
            `BRSC_OFS_FRAME_CLOCK: bus.rdata = bus.frame_clock;
            default: bus.rdata = `BRSC_READ_NONE;
        endcase
    end
endmodule

// >>> src/brsc_top.sv
// route control bank: transceiver pin configuration and signal routing selectors
// What this block does
// - Pin config bit 4 drives the bus-mode pin, 0 parallel, 1 serial host bus.
// - Pin config bit 2 drives the data-width pin, 0 for 8-bit, 1 for 16-bit.
// - Pin config bit 1 drives the strobe-style pin, 0 separate strobes, 1 data strobe.
// - Pin config bit 0 drives the address/data multiplex pin, 1 meaning multiplexed.
// - Pin config bit 3 drives the float test input and resets to one.
// - Pin config bits 7, 6, 5 drive serial clock polarity, phase and bit swap.
// - Line data low nibble selects the rx positive rail source from the code set.
// - Line data high nibble selects the rx negative rail source, code 1 tx negative rail.
// - Line clock low nibble selects the rx line clock source; upper nibble unused.
// - Overhead high nibble selects the tx overhead enable source.
// - Overhead low nibble selects the tx overhead data source.
// - Serial data low nibble selects the tx serial data source; upper nibble unused.
// - Frame/clock high nibble selects the tx frame start input source.
// - Frame/clock low nibble selects the tx clock input source.
// - Registers are reached by plain microcontroller reads and writes at byte offsets.
`timescale 1ns/1ps
`include "brsc_defs.svh"
module brsc_top
    import brsc_pkg::*;
(
    // clock, reset, enable
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    // microcontroller bus
    input wire logic mcu_cs_n_in,
    input wire logic mcu_rd_n_in,
    input wire logic mcu_wr_n_in,
    input wire logic [3:0] mcu_addr_in,
    input wire logic [7:0] mcu_data_in,
    output logic [7:0] mcu_data_out,
    output logic mcu_data_oe_out,
    // transceiver configuration pins
    output logic serial_clock_polarity_sel_out,
    output logic serial_clock_phase_sel_out,
    output logic serial_bit_swap_sel_out,
    output logic serial_bus_mode_sel_out,
    output logic output_float_test_out,
    output logic data_width_sel_out,
    output logic strobe_style_sel_out,
    output logic addr_data_mux_sel_out,
    // routing sources
    input wire logic tx_positive_rail_in,
    input wire logic tx_negative_rail_in,
    input wire logic tx_line_clock_in,
    input wire logic osc_t3_in,
    input wire logic osc_e3_in,
    input wire logic osc_sts1_in,
    input wire logic coax_connector_in,
    input wire logic tx_overhead_frame_start_in,
    input wire logic rx_overhead_frame_start_in,
    input wire logic rx_overhead_data_in,
    input wire logic rx_serial_data_in,
    input wire logic tx_frame_start_out_in,
    input wire logic rx_frame_start_out_in,
    input wire logic tx_clock_out_in,
    input wire logic rx_recovered_clock_out_in,
    // routed transceiver inputs, level and drive enable
    output logic rx_positive_rail_out,
    output logic rx_positive_rail_oe_out,
    output logic rx_negative_rail_out,
    output logic rx_negative_rail_oe_out,
    output logic rx_line_clock_out,
    output logic rx_line_clock_oe_out,
    output logic tx_overhead_enable_out,
    output logic tx_overhead_enable_oe_out,
    output logic tx_overhead_data_out,
    output logic tx_overhead_data_oe_out,
    output logic tx_serial_data_out,
    output logic tx_serial_data_oe_out,
    output logic tx_frame_start_in_out,
    output logic tx_frame_start_in_oe_out,
    output logic tx_clock_in_out,
    output logic tx_clock_in_oe_out
);
    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // routed signals are resampled at 250 MHz: a routed clock gets up to 4 ns jitter
    localparam int NSRC = 14;
    localparam int NBUS = 15;
    logic [NSRC-1:0] src_meta_q;
    logic [NSRC-1:0] src_q;
    logic [NBUS-1:0] bus_meta_q;
    logic [NBUS-1:0] bus_q;
    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    brsc_addr_t addr_s;
    brsc_reg_t data_s;

    always_ff @(posedge clock_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            src_meta_q <= '0;
            src_q <= '0;
            bus_meta_q <= {3'b111, 12'h000};
            bus_q <= {3'b111, 12'h000};
        end
        else if (ce_in)
        begin
            src_meta_q <= {rx_recovered_clock_out_in, tx_clock_out_in, rx_frame_start_out_in,
                tx_frame_start_out_in, rx_serial_data_in, rx_overhead_data_in,
                rx_overhead_frame_start_in, tx_overhead_frame_start_in, coax_connector_in,
                osc_sts1_in, osc_e3_in, osc_t3_in, tx_line_clock_in, tx_negative_rail_in};
            src_q <= src_meta_q;
            bus_meta_q <= {mcu_cs_n_in, mcu_rd_n_in, mcu_wr_n_in, mcu_addr_in, mcu_data_in};
            bus_q <= bus_meta_q;
        end
    end

    assign {cs_n_s, rd_n_s, wr_n_s, addr_s, data_s} = bus_q;

    logic pos_rail_meta_q;

    always_ff @(posedge clock_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pos_rail_meta_q <= 1'b0;
        end
        else if (ce_in)
        begin
            pos_rail_meta_q <= tx_positive_rail_in;
        end
    end

    logic pos_rail_q;

    always_ff @(posedge clock_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pos_rail_q <= 1'b0;
        end
        else if (ce_in)
        begin
            pos_rail_q <= pos_rail_meta_q;
        end
    end

    // ************************************************************
    // microcontroller bus front end
    // ************************************************************
    brsc_bus_state_t state_q;
    logic wr_stb_q;
    brsc_addr_t addr_q;
    brsc_reg_t wdata_q;
    brsc_reg_if regs ();

    // address and data ride the same synchroniser depth as the strobes
    always_ff @(posedge clock_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= BRSC_BUS_IDLE;
            wr_stb_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
        end
        else if (ce_in)
        begin
            wr_stb_q <= 1'b0;
            case (state_q)
                BRSC_BUS_IDLE:
                begin
                    addr_q <= addr_s;
                    if (!cs_n_s && !wr_n_s)
                    begin
                        wr_stb_q <= 1'b1;
                        wdata_q <= data_s;
                        state_q <= BRSC_BUS_WRITE;
                    end
                    else if (!cs_n_s && !rd_n_s)
                    begin
                        state_q <= BRSC_BUS_READ;
                    end
                end
                BRSC_BUS_WRITE:
                begin
                    // one store per strobe, however long the strobe lasts
                    if (cs_n_s || wr_n_s)
                    begin
                        state_q <= BRSC_BUS_IDLE;
                    end
                end
                BRSC_BUS_READ:
                begin
                    if (cs_n_s || rd_n_s)
                    begin
                        state_q <= BRSC_BUS_IDLE;
                    end
                end
                default:
                begin
                    state_q <= BRSC_BUS_IDLE;
                end
            endcase
        end
    end

    assign regs.wr_stb = wr_stb_q;
    assign regs.addr = addr_q;
    assign regs.wdata = wdata_q;

    brsc_reg_bank u_bank
    (
        .clk_in(clock_in),
        .rst_n_in(rst_n_q),
        .ce_in(ce_in),
        .bus(regs.bank)
    );

    always_ff @(posedge clock_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            mcu_data_out <= `BRSC_READ_NONE;
            mcu_data_oe_out <= 1'b0;
        end
        else if (ce_in)
        begin
            mcu_data_oe_out <= (state_q == BRSC_BUS_READ) && !cs_n_s && !rd_n_s;
            mcu_data_out <= regs.rdata;
        end
    end

    // ************************************************************
    // transceiver configuration pins
    // ************************************************************
    always_ff @(posedge clock_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            {serial_clock_polarity_sel_out, serial_clock_phase_sel_out,
                serial_bit_swap_sel_out, serial_bus_mode_sel_out, output_float_test_out,
                data_width_sel_out, strobe_style_sel_out, addr_data_mux_sel_out}
                <= `BRSC_RST_PIN_CFG;
        end
        else if (ce_in)
        begin
            // the serial options are driven always; the transceiver heeds them in serial mode
            serial_clock_polarity_sel_out <= regs.pin_cfg[`BRSC_BIT_CLK_POL];
            serial_clock_phase_sel_out <= regs.pin_cfg[`BRSC_BIT_CLK_PHASE];
            serial_bit_swap_sel_out <= regs.pin_cfg[`BRSC_BIT_BIT_SWAP];
            serial_bus_mode_sel_out <= regs.pin_cfg[`BRSC_BIT_BUS_MODE];
            output_float_test_out <= regs.pin_cfg[`BRSC_BIT_FLOAT_TEST];
            data_width_sel_out <= regs.pin_cfg[`BRSC_BIT_WIDTH];
            strobe_style_sel_out <= regs.pin_cfg[`BRSC_BIT_STROBE];
            addr_data_mux_sel_out <= regs.pin_cfg[`BRSC_BIT_ADDR_MUX];
        end
    end

    // ************************************************************
    // routing selectors
    // ************************************************************
    logic [3:0] osc_coax;

    // coax, then the three oscillators, as codes 5 down to 2
    assign osc_coax = {src_q[5], src_q[4], src_q[3], src_q[2]};

    brsc_route_sel #(.VALID(`BRSC_VALID_LINE)) u_rx_pos
    (
        .clk_in(clock_in), .rst_n_in(rst_n_q), .ce_in(ce_in),
        .code_in(regs.line_data[3:0]), .src_in({osc_coax, pos_rail_q}),
        .val_out(rx_positive_rail_out), .oe_out(rx_positive_rail_oe_out)
    );

    brsc_route_sel #(.VALID(`BRSC_VALID_LINE)) u_rx_neg
    (
        .clk_in(clock_in), .rst_n_in(rst_n_q), .ce_in(ce_in),
        .code_in(regs.line_data[7:4]), .src_in({osc_coax, src_q[0]}),
        .val_out(rx_negative_rail_out), .oe_out(rx_negative_rail_oe_out)
    );

    brsc_route_sel #(.VALID(`BRSC_VALID_LINE)) u_rx_line_clk
    (
        .clk_in(clock_in), .rst_n_in(rst_n_q), .ce_in(ce_in),
        .code_in(regs.line_clock[3:0]), .src_in({osc_coax, src_q[1]}),
        .val_out(rx_line_clock_out), .oe_out(rx_line_clock_oe_out)
    );

    // two-source and one-source selectors float on their unused codes
    brsc_route_sel #(.VALID(`BRSC_VALID_TWO_SRC)) u_ohen
    (
        .clk_in(clock_in), .rst_n_in(rst_n_q), .ce_in(ce_in),
        .code_in(regs.overhead[7:4]), .src_in({3'b000, src_q[7], src_q[6]}),
        .val_out(tx_overhead_enable_out), .oe_out(tx_overhead_enable_oe_out)
    );

    brsc_route_sel #(.VALID(`BRSC_VALID_ONE_SRC)) u_ohd
    (
        .clk_in(clock_in), .rst_n_in(rst_n_q), .ce_in(ce_in),
        .code_in(regs.overhead[3:0]), .src_in({4'h0, src_q[8]}),
        .val_out(tx_overhead_data_out), .oe_out(tx_overhead_data_oe_out)
    );

    brsc_route_sel #(.VALID(`BRSC_VALID_ONE_SRC)) u_tx_serial
    (
        .clk_in(clock_in), .rst_n_in(rst_n_q), .ce_in(ce_in),
        .code_in(regs.serial_data[3:0]), .src_in({4'h0, src_q[9]}),
        .val_out(tx_serial_data_out), .oe_out(tx_serial_data_oe_out)
    );

    brsc_route_sel #(.VALID(`BRSC_VALID_TWO_SRC)) u_tsof
    (
        .clk_in(clock_in), .rst_n_in(rst_n_q), .ce_in(ce_in),
        .code_in(regs.frame_clock[7:4]), .src_in({3'b000, src_q[11], src_q[10]}),
        .val_out(tx_frame_start_in_out), .oe_out(tx_frame_start_in_oe_out)
    );

    brsc_route_sel #(.VALID(`BRSC_VALID_TWO_SRC)) u_tclk
    (
        .clk_in(clock_in), .rst_n_in(rst_n_q), .ce_in(ce_in),
        .code_in(regs.frame_clock[3:0]), .src_in({3'b000, src_q[13], src_q[12]}),
        .val_out(tx_clock_in_out), .oe_out(tx_clock_in_oe_out)
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_q);

    property p_bus_mode;
        ce_in |=> serial_bus_mode_sel_out == $past(regs.pin_cfg[`BRSC_BIT_BUS_MODE]);
    endproperty
    a_bus_mode: assert property (p_bus_mode) else $error("bus mode pin mismatch");

    property p_width;
        ce_in |=> data_width_sel_out == $past(regs.pin_cfg[`BRSC_BIT_WIDTH]);
    endproperty
    a_width: assert property (p_width) else $error("width pin mismatch");

    property p_strobe;
        ce_in |=> strobe_style_sel_out == $past(regs.pin_cfg[`BRSC_BIT_STROBE]);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe pin mismatch");

    property p_mux_pin;
        ce_in |=> addr_data_mux_sel_out == $past(regs.pin_cfg[`BRSC_BIT_ADDR_MUX]);
    endproperty
    a_mux_pin: assert property (p_mux_pin) else $error("mux pin mismatch");

    property p_float_reset;
        $rose(rst_n_q) |-> output_float_test_out && regs.pin_cfg[`BRSC_BIT_FLOAT_TEST];
    endproperty
    a_float_reset: assert property (p_float_reset) else $error("float test not set");

    property p_serial_opts;
        ce_in |=> {serial_clock_polarity_sel_out, serial_clock_phase_sel_out,
            serial_bit_swap_sel_out} == $past(regs.pin_cfg[7:5]);
    endproperty
    a_serial_opts: assert property (p_serial_opts) else $error("serial options");

    property p_rx_pos_low;
        ce_in && regs.line_data[3:0] == `BRSC_CODE_LOW |=> rx_positive_rail_oe_out
            && !rx_positive_rail_out;
    endproperty
    a_rx_pos_low: assert property (p_rx_pos_low) else $error("positive rail low code");

    property p_rx_neg_loop;
        ce_in && regs.line_data[7:4] == `BRSC_CODE_LOOP |=> rx_negative_rail_oe_out
            && rx_negative_rail_out == $past(src_q[0]);
    endproperty
    a_rx_neg_loop: assert property (p_rx_neg_loop) else $error("negative rail loop");

    property p_ohen_unused;
        ce_in && regs.overhead[7:4] inside {4'h0, 4'h3, 4'h4, 4'h5}
            |=> !tx_overhead_enable_oe_out;
    endproperty
    a_ohen_unused: assert property (p_ohen_unused) else $error("unused code drives");

    property p_tx_serial_high_code;
        ce_in && regs.serial_data[3:0] > `BRSC_CODE_LAST |=> !tx_serial_data_oe_out;
    endproperty
    a_tx_serial_high_code: assert property (p_tx_serial_high_code)
        else $error("serial data drives");

    property p_unused_zero;
        regs.line_clock[7:4] == 4'h0 && regs.serial_data[7:4] == 4'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

    property p_write_lands;
        ce_in && wr_stb_q && addr_q == `BRSC_OFS_FRAME_CLOCK |=> regs.frame_clock
            == $past(wdata_q);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write lost");

    c_write: cover property (ce_in && wr_stb_q);
    c_read: cover property (mcu_data_oe_out ##1 !mcu_data_oe_out);
    c_serial_mode: cover property (serial_bus_mode_sel_out && !output_float_test_out);
    c_tclk_route: cover property (tx_clock_in_oe_out && regs.frame_clock[3:0] == 4'h2);
endmodule

// >>> verif/brsc_src_model.sv
// stand-in for the transceiver and oscillators feeding the routing sources
`timescale 1ns/1ps
module brsc_src_model
(
    // requested levels
    input wire logic [14:0] level_in,
    // source pins
    output logic [14:0] src_out
);
    assign src_out = level_in;
endmodule

// >>> verif/tb_brsc_top.sv
// self-checking bench for the route control bank
`timescale 1ns/1ps
module tb_brsc_top;
    import brsc_pkg::*;
    // ********
    // signals
    // ********
    logic clock_in = 1'b0, arst_n_in = 1'b0, ce_in = 1'b1;
    logic mcu_cs_n_in = 1'b1, mcu_rd_n_in = 1'b1, mcu_wr_n_in = 1'b1;
    brsc_addr_t mcu_addr_in = 4'h0;
    brsc_reg_t mcu_data_in = 8'h00, mcu_data_out, cfg;
    logic mcu_data_oe_out;
    logic [14:0] lvl = 15'h0000, src;
    logic [7:0] rv, ro;
    int n_errors = 0, tests_run = 0, sx;
    // addr, shift, then source index for codes 5..1 (f = none)
    logic [27:0] tbl [8] = '{28'h9065430, 28'h9465431, 28'ha065432, 28'hb4fff87,
        28'hb0ffff9, 28'hc0ffffa, 28'hd4fffcb, 28'hd0fffed};
    brsc_src_model far (.level_in(lvl), .src_out(src));
    brsc_top uut (.*,
        .serial_clock_polarity_sel_out(cfg[7]), .serial_clock_phase_sel_out(cfg[6]),
        .serial_bit_swap_sel_out(cfg[5]), .serial_bus_mode_sel_out(cfg[4]),
        .output_float_test_out(cfg[3]), .data_width_sel_out(cfg[2]),
        .strobe_style_sel_out(cfg[1]), .addr_data_mux_sel_out(cfg[0]),
        .tx_positive_rail_in(src[0]), .tx_negative_rail_in(src[1]), .tx_line_clock_in(src[2]),
        .osc_t3_in(src[3]), .osc_e3_in(src[4]), .osc_sts1_in(src[5]), .coax_connector_in(src[6]),
        .tx_overhead_frame_start_in(src[7]), .rx_overhead_frame_start_in(src[8]),
        .rx_overhead_data_in(src[9]), .rx_serial_data_in(src[10]),
        .tx_frame_start_out_in(src[11]), .rx_frame_start_out_in(src[12]),
        .tx_clock_out_in(src[13]), .rx_recovered_clock_out_in(src[14]),
        .rx_positive_rail_out(rv[0]), .rx_positive_rail_oe_out(ro[0]),
        .rx_negative_rail_out(rv[1]), .rx_negative_rail_oe_out(ro[1]),
        .rx_line_clock_out(rv[2]), .rx_line_clock_oe_out(ro[2]),
        .tx_overhead_enable_out(rv[3]), .tx_overhead_enable_oe_out(ro[3]),
        .tx_overhead_data_out(rv[4]), .tx_overhead_data_oe_out(ro[4]),
        .tx_serial_data_out(rv[5]), .tx_serial_data_oe_out(ro[5]),
        .tx_frame_start_in_out(rv[6]), .tx_frame_start_in_oe_out(ro[6]),
        .tx_clock_in_out(rv[7]), .tx_clock_in_oe_out(ro[7]));
    // ********
    // tasks
    // ********
    always #2 clock_in = ~clock_in;
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // strobes are synchronised, so address settles two clocks ahead
    task automatic wr(input brsc_addr_t a, input brsc_reg_t d);
        @(posedge clock_in);
        mcu_addr_in <= a;
        mcu_data_in <= d;
        cyc(2);
        {mcu_cs_n_in, mcu_wr_n_in} <= 2'b00;
        cyc(4);
        {mcu_cs_n_in, mcu_wr_n_in} <= 2'b11;
        cyc(4);
    endtask
    task automatic rd(input brsc_addr_t a, input brsc_reg_t e);
        @(posedge clock_in);
        mcu_addr_in <= a;
        cyc(2);
        {mcu_cs_n_in, mcu_rd_n_in} <= 2'b00;
        cyc(7);
        chk({7'h00, mcu_data_oe_out}, 8'h01);
        chk(mcu_data_out, e);
        {mcu_cs_n_in, mcu_rd_n_in} <= 2'b11;
        cyc(5);
    endtask
    task automatic results;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #40000;
        n_errors++;
        results;
    end
    initial
    begin
        cyc(16);
        arst_n_in <= 1'b1;
        cyc(4);
        chk(cfg, 8'h08);
        chk(ro, 8'h00);
        rd(4'h8, 8'h08);
        rd(4'h9, 8'h08);
        for (int a = 10; a < 14; a++)
            rd(a[3:0], 8'h00);
        rd(4'h3, 8'h00);
        wr(4'ha, 8'hff);
        rd(4'ha, 8'h0f);
        wr(4'hc, 8'hff);
        rd(4'hc, 8'h0f);
        for (int i = 0; i < 8; i++)
        begin
            wr(4'h8, 8'h01 << i);
            chk(cfg, 8'h01 << i);
        end
        wr(4'h3, 8'h55);
        // frozen clock enable: the strobe goes unseen
        ce_in <= 1'b0;
        wr(4'h8, 8'h10);
        chk(cfg, 8'h80);
        ce_in <= 1'b1;
        rd(4'h8, 8'h80);
        for (int f = 0; f < 8; f++)
            for (int c = 0; c < 16; c++)
            begin
                wr(4'(tbl[f][27:24]), 8'(c << tbl[f][23:20]));
                sx = (c > 0 && c < 6) ? int'(tbl[f][4*(c-1) +: 4]) : 15;
                // lone level on the chosen source, so a wrong pick shows
                for (int p = 0; p < 2; p++)
                begin
                    lvl <= p[0] ? 15'(1 << sx) : ~15'(1 << sx);
                    cyc(5);
                    chk({6'h00, ro[f], rv[f]}, (sx < 15) ? {7'h01, p[0]} : (c == 6) ? 8'h02 :
                        (c == 7) ? 8'h03 :
                        8'h00);
                end
            end
        results;
    end
endmodule
